/* File: design/hpp_pkg.sv */
// Purpose: Shared constants of the parallel host port handshake.
// Assumes: All pins are synchronous to the 25 MHz clock.
// Notes:   Access codes follow the select lines of the port.
package hpp_pkg;
  localparam int          CPU_PERIOD_NS  = 40;
  localparam int          STRB_LOW_NS    = 4 * CPU_PERIOD_NS;
  localparam int          STRB_HIGH_NS   = 4 * CPU_PERIOD_NS;
  localparam int          DATA_LEAD_NS   = 2 * CPU_PERIOD_NS;
  localparam int          STRB_LOW_CYC   = (STRB_LOW_NS + CPU_PERIOD_NS - 1) / CPU_PERIOD_NS;
  localparam int          STRB_HIGH_CYC  = (STRB_HIGH_NS + CPU_PERIOD_NS - 1) / CPU_PERIOD_NS;
  localparam int          DATA_LEAD_CYC  = (DATA_LEAD_NS + CPU_PERIOD_NS - 1) / CPU_PERIOD_NS;
  localparam logic [1:0]  ACC_CTRL       = 2'h0;
  localparam logic [1:0]  ACC_DATA_INC   = 2'h1;
  localparam logic [1:0]  ACC_ADDR       = 2'h2;
  localparam logic [1:0]  ACC_DATA_FIX   = 2'h3;
  localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;
  localparam int          FIFO_DEPTH     = 32;
  localparam int          FIFO_WIDTH     = 64;
endpackage

/* File: design/hpp_if.sv */
`timescale 1ns/1ns
// Purpose: Pins of the parallel host port between host and device.
// Assumes: Both ends share one clock.
// Notes:   The shared data bus level is resolved here from the enables.
interface hpp_if;
  logic        host_chip_select;
  logic        data_strobe_one;
  logic        data_strobe_two;
  logic        address_strobe;
  logic [1:0]  access_type_select;
  logic        read_write_select;
  logic        halfword_identifier;
  logic        host_ready;
  logic [15:0] hd_host_out;
  logic        hd_host_oe;
  logic [15:0] hd_dev_out;
  logic        hd_dev_oe;
  logic [15:0] host_data_bus;

  // Device drive wins; an undriven bus reads as zero.
  assign host_data_bus = hd_dev_oe ? hd_dev_out : (hd_host_oe ? hd_host_out : 16'h0000);

  modport dev (input host_chip_select, data_strobe_one, data_strobe_two, address_strobe,
               access_type_select, read_write_select, halfword_identifier, host_data_bus,
               output host_ready, hd_dev_out, hd_dev_oe);
  modport host (output host_chip_select, data_strobe_one, data_strobe_two, address_strobe,
                access_type_select, read_write_select, halfword_identifier, hd_host_out,
                hd_host_oe, input host_ready, host_data_bus);
endinterface

/* File: design/hpp_fifo.sv */
`timescale 1ns/1ns
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes:   Full and empty come from a count one wider than the index.
module hpp_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Full and empty flags straight from the occupancy count.
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // Storage write needs no reset.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: design/hpp_device.sv */
`timescale 1ns/1ns
// Purpose: Device end of the host port: select capture, half-word
//          assembly, ready pacing and fetch or store of data words.
// Assumes: Pins synchronous to clock; read_write_select high means read.
// Notes:   Stores pass a FIFO to the memory side; fetches wait for it
//          to drain so a read never overtakes a queued write.
module hpp_device (
  input  wire logic  clock,
  input  wire logic  rst_n,
  hpp_if.dev         port,
  output logic       mem_wr_valid,
  input  wire logic  mem_wr_ready,
  output logic [31:0] mem_wr_addr,
  output logic [31:0] mem_wr_data,
  output logic       mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input  wire logic  mem_rd_valid,
  input  wire logic [31:0] mem_rd_data,
  output logic [31:0] ctrl_word
);
  import hpp_pkg::*;

  logic        strb_q;
  logic        as_q;
  logic        as_cap_q;
  logic [3:0]  as_sel_q;
  logic [3:0]  acc_q;
  logic [31:0] ctrl_q;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic        data_ok_q;
  logic [15:0] wlo_q;
  logic        rd_wait_q;
  logic [1:0]  lead_q;
  logic        push_q;
  logic [63:0] push_word_q;
  logic [15:0] hd_out_q;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [63:0] fifo_out_data;

  // Internal strobe, active low.
  wire strobe_n    = ~(port.data_strobe_one ^ port.data_strobe_two)
                     | port.host_chip_select;
  wire strobe_fall = strb_q & ~strobe_n;
  wire strobe_rise = ~strb_q & strobe_n;
  wire as_fall     = as_q & ~port.address_strobe;

  // Select lines: taken from the address strobe capture if one was seen,
  // otherwise straight from the pins at the strobe fall.
  wire [3:0] sel_now = {port.access_type_select, port.read_write_select,
                        port.halfword_identifier};
  wire [3:0] sel     = as_cap_q ? as_sel_q : sel_now;
  wire [3:0] cur     = strobe_fall ? sel : acc_q;

  // Decoding of the access now starting and the access in progress.
  wire fall_data = (sel[3:2] == ACC_DATA_INC) | (sel[3:2] == ACC_DATA_FIX);
  wire fall_rd   = sel[1];
  wire fall_hw2  = sel[0];
  wire acc_inc   = (acc_q[3:2] == ACC_DATA_INC);
  wire acc_data  = acc_inc | (acc_q[3:2] == ACC_DATA_FIX);
  wire acc_rd    = acc_q[1];
  wire acc_hw2   = acc_q[0];
  wire [31:0] wr_word = {port.host_data_bus, wlo_q};

  // A first data half-word read with no fetched word starts a fetch.
  wire rd_start = strobe_fall & fall_data & fall_rd & ~fall_hw2 & ~data_ok_q;
  // Busy covers an outstanding fetch, the data lead time and a queued push.
  wire busy     = rd_wait_q | (lead_q != 2'h0) | push_q;

  // Ready is forced low while deselected; control and address accesses
  // add nothing to it. The host sees busy only while it holds chip select
  // low, so a push or prefetch still running when the next access starts holds that access in setup until it ends.
  assign port.host_ready = ~port.host_chip_select & (rd_start | busy);

  // Read data source: the freshly fetched word wins in its load cycle.
  wire [31:0] rd_src  = (cur[3:2] == ACC_CTRL) ? ctrl_q :
                        (cur[3:2] == ACC_ADDR) ? addr_q :
                        (mem_rd_valid ? mem_rd_data : data_q);
  wire [15:0] rd_half = cur[0] ? rd_src[31:16] : rd_src[15:0];

  // Bus drive during a read strobe; data itself comes from a flip-flop.
  assign port.hd_dev_out = hd_out_q;
  assign port.hd_dev_oe  = ~strobe_n & cur[1];

  // Memory side: a fetch waits for queued stores to drain first, since a
  // fetch that overtook a queued store would return stale data.
  assign mem_rd_req  = rd_wait_q & ~fifo_out_valid & ~push_q;
  assign mem_rd_addr = addr_q;
  assign mem_wr_valid = fifo_out_valid;
  assign mem_wr_addr  = fifo_out_data[63:32];
  assign mem_wr_data  = fifo_out_data[31:0];
  assign ctrl_word    = ctrl_q;

  // Edge history and address strobe capture, once per strobe period.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strb_q   <= 1'b1;
      as_q     <= 1'b1;
      as_cap_q <= 1'b0;
      as_sel_q <= 4'h0;
    end else begin
      strb_q <= strobe_n;
      as_q   <= port.address_strobe;
      if (strobe_rise) begin
        as_cap_q <= 1'b0;
      end else if (as_fall && !as_cap_q) begin
        as_cap_q <= 1'b1;
        as_sel_q <= sel_now;
      end
    end
  end

  // Access held from the strobe fall to its rise.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_q    <= 4'h0;
      hd_out_q <= 16'h0000;
    end else begin
      if (strobe_fall) acc_q <= sel;
      hd_out_q <= rd_half;
    end
  end

  // Fetch handshake and data lead counter; data is stable on the bus for
  // the lead time before ready goes low.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_wait_q <= 1'b0;
      lead_q    <= 2'h0;
    end else begin
      if (mem_rd_req && mem_rd_valid) begin
        rd_wait_q <= 1'b0;
        lead_q    <= 2'(DATA_LEAD_CYC);
      end else begin
        if (rd_start) rd_wait_q <= 1'b1;
        if (strobe_rise && acc_data && acc_rd && acc_hw2 && acc_inc) begin
          rd_wait_q <= 1'b1;
        end
        if (lead_q != 2'h0) lead_q <= lead_q - 2'h1;
      end
    end
  end

  // Register and word assembly. Writes are taken at the strobe rise,
  // when the host data is valid.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q      <= CTRL_RESET;
      addr_q      <= ADDR_RESET;
      data_q      <= 32'h0000_0000;
      data_ok_q   <= 1'b0;
      wlo_q       <= 16'h0000;
      push_q      <= 1'b0;
      push_word_q <= 64'h0000_0000_0000_0000;
    end else begin
      if (push_q && fifo_in_ready) push_q <= 1'b0;
      if (mem_rd_req && mem_rd_valid) begin
        data_q    <= mem_rd_data;
        data_ok_q <= 1'b1;
      end
      if (strobe_rise && !acc_rd) begin
        if (!acc_hw2) begin
          wlo_q <= port.host_data_bus;
        end else if (acc_q[3:2] == ACC_CTRL) begin
          ctrl_q <= wr_word;
        end else if (acc_q[3:2] == ACC_ADDR) begin
          // A fetched word belongs to the old address and is dropped.
          addr_q    <= wr_word;
          data_ok_q <= 1'b0;
        end else begin
          push_q      <= 1'b1;
          push_word_q <= {addr_q, wr_word};
          data_ok_q   <= 1'b0;
          if (acc_inc) addr_q <= addr_q + ADDR_STEP;
        end
      end
      if (strobe_rise && acc_rd && acc_data && acc_hw2) begin
        data_ok_q <= 1'b0;
        if (acc_inc) addr_q <= addr_q + ADDR_STEP;
      end
    end
  end

  // Store queue towards memory; a full queue holds the port busy.
  // Only a stalled memory side ever lets it fill, and then the host
  // simply waits at chip select for room.
  hpp_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) i_hpp_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word_q),
    .out_valid (fifo_out_valid),
    .out_ready (mem_wr_ready),
    .out_data  (fifo_out_data)
  );
endmodule

/* File: design/hpp_host.sv */
`timescale 1ns/1ns
// Purpose: Host end of the port: runs one 32-bit access as two
//          half-word strobes with the required pacing.
// Assumes: Device answers on the shared interface with the same clock.
// Notes:   Only data_strobe_one toggles; data_strobe_two stays high.
module hpp_host (
  input  wire logic        clock,
  input  wire logic        rst_n,
  hpp_if.host              port,
  input  wire logic        use_addr_strobe,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_type,
  input  wire logic        cmd_write,
  input  wire logic [31:0] cmd_wdata,
  output logic             resp_valid,
  output logic [31:0]      resp_rdata
);
  import hpp_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_STRB  = 4'b0100,
    H_GAP   = 4'b1000
  } hpp_state_e;

  hpp_state_e  st_q;
  logic        half_q;
  logic [2:0]  cnt_q;
  logic [1:0]  type_q;
  logic        write_q;
  logic [31:0] wdata_q;
  logic [15:0] rlo_q;
  logic        first_q;

  wire low_done  = (cnt_q >= 3'(STRB_LOW_CYC - 1)) & ~port.host_ready;
  wire high_done = (cnt_q >= 3'(STRB_HIGH_CYC - 1));

  // Pin drive decoded from the state.
  assign cmd_ready                = (st_q == H_IDLE);
  assign port.host_chip_select    = (st_q == H_IDLE) | (st_q == H_GAP);
  assign port.data_strobe_one     = (st_q != H_STRB);
  assign port.data_strobe_two     = 1'b1;
  // One address strobe pulse per strobe, or tied high when unused.
  assign port.address_strobe      = ~(use_addr_strobe & (((st_q == H_SETUP) & ~port.host_ready)
                                    | ((st_q == H_STRB) & first_q)));
  assign port.access_type_select  = type_q;
  assign port.read_write_select   = ~write_q;
  assign port.halfword_identifier = half_q;
  assign port.hd_host_out         = half_q ? wdata_q[31:16] : wdata_q[15:0];
  // Write data stays on the bus through the gap: the device takes it at the
  // first edge that sees the strobe high, one cycle after the release.
  assign port.hd_host_oe          = write_q & ((st_q == H_STRB) | (st_q == H_GAP));

  // Sequencer.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q       <= H_IDLE;
      half_q     <= 1'b0;
      cnt_q      <= 3'h0;
      type_q     <= ACC_CTRL;
      write_q    <= 1'b0;
      wdata_q    <= 32'h0000_0000;
      rlo_q      <= 16'h0000;
      first_q    <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0000_0000;
    end else begin
      resp_valid <= 1'b0;
      if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
      unique case (st_q)
        H_IDLE: begin
          if (cmd_valid) begin
            type_q  <= cmd_type;
            write_q <= cmd_write;
            wdata_q <= cmd_wdata;
            half_q  <= 1'b0;
            st_q    <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (!port.host_ready) begin
            st_q    <= H_STRB;
            cnt_q   <= 3'h0;
            first_q <= 1'b1;
          end
        end
        H_STRB: begin
          first_q <= 1'b0;
          if (low_done) begin
            if (half_q) resp_rdata <= {port.host_data_bus, rlo_q};
            else rlo_q <= port.host_data_bus;
            st_q  <= H_GAP;
            cnt_q <= 3'h0;
          end
        end
        H_GAP: begin
          if (high_done) begin
            if (!half_q) begin
              half_q <= 1'b1;
              st_q   <= H_SETUP;
            end else begin
              resp_valid <= 1'b1;
              st_q       <= H_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

/* File: verification/hpp_monitor.sv */
`timescale 1ns/1ns
// Purpose: Pin checks between the host end and the device end of the port.
// Assumes: One clock; rst_n synchronous and active low.
// Notes:   Only pins are seen, so the strobe is rebuilt here.
module hpp_monitor (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        host_chip_select,
  input wire logic        data_strobe_one,
  input wire logic        data_strobe_two,
  input wire logic        address_strobe,
  input wire logic [1:0]  access_type_select,
  input wire logic        host_ready,
  input wire logic        hd_dev_oe,
  input wire logic [15:0] host_data_bus
);
  // Active-low strobe as both ends must form it.
  wire strobe_n = ~(data_strobe_one ^ data_strobe_two) | host_chip_select;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Edges and the four-clock width floor of each strobe phase.
  sequence s_fall;
    $fell(strobe_n);
  endsequence
  sequence s_rise;
    $rose(strobe_n);
  endsequence
  sequence s_low4;
    !strobe_n [*4];
  endsequence
  sequence s_high4;
    strobe_n [*4];
  endsequence

  // The device may only drive the bus inside a strobe.
  chk_oe_in_strobe: assert property (hd_dev_oe |-> !strobe_n)
    else $error("device drives bus outside strobe");
  chk_ready_deselect: assert property (host_chip_select |-> !host_ready)
    else $error("ready high while deselected");
  chk_ready_midstrobe: assert property (!strobe_n && $past(!strobe_n) |-> !$rose(host_ready))
    else $error("ready rose inside a held strobe");
  chk_ready_bound: assert property ($rose(host_ready) |-> ##[1:1000] !host_ready)
    else $error("ready stuck high");
  chk_ctrl_quiet: assert property (s_fall ##0 !access_type_select[0] |-> !host_ready [*4])
    else $error("ready raised by control or address access");
  chk_release_ready: assert property (s_rise |-> $past(host_ready) == 1'b0)
    else $error("strobe released before ready low");
  chk_as_once: assert property (!strobe_n && $past(!strobe_n) |-> !$fell(address_strobe))
    else $error("second address strobe in one strobe");
  chk_low_width: assert property (s_fall |-> s_low4)
    else $error("strobe low too short");
  chk_high_width: assert property (s_rise |-> s_high4)
    else $error("strobe high too short");
  chk_data_lead: assert property ($fell(host_ready) && hd_dev_oe |->
                                  host_data_bus == $past(host_data_bus, 2))
    else $error("read data not settled two clocks before ready low");
endmodule

/* File: verification/tb_host_port_handshake.sv */
`timescale 1ns/1ns
// Purpose: Joins host and device ends and checks words round trip.
// Assumes: Memory answers after a random wait and stalls at will.
// Notes:   Seed 79; expectations come from a shadow memory.
module tb_host_port_handshake;
  import hpp_pkg::*;
  logic        clock, rst_n, use_addr_strobe, cmd_valid, cmd_ready, cmd_write;
  logic [1:0]  cmd_type;
  logic [31:0] cmd_wdata, resp_rdata, mem_wr_addr, mem_wr_data, mem_rd_addr, ctrl_word;
  logic        resp_valid, mem_wr_valid, mem_rd_req, strobe_q, wr_low_q;
  logic        mem_wr_ready = 1'b0;
  logic        mem_rd_valid = 1'b0;
  logic [31:0] mem_rd_data  = 32'h0000_0000;
  logic [15:0] low_half_q;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] exp_mem [logic [31:0]];
  int          seed = 79;
  int          stall = 0;
  int          rd_wait = 0;
  int          mismatches = 0;
  int          check_count = 0;

  hpp_if bus ();
  hpp_device i_hpp_device (.clock(clock), .rst_n(rst_n), .port(bus),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .ctrl_word(ctrl_word));
  hpp_host i_hpp_host (.clock(clock), .rst_n(rst_n), .port(bus),
    .use_addr_strobe(use_addr_strobe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_type(cmd_type), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata));
  hpp_monitor i_hpp_monitor (.clock(clock), .rst_n(rst_n),
    .host_chip_select(bus.host_chip_select), .data_strobe_one(bus.data_strobe_one),
    .data_strobe_two(bus.data_strobe_two), .address_strobe(bus.address_strobe),
    .access_type_select(bus.access_type_select), .host_ready(bus.host_ready),
    .hd_dev_oe(bus.hd_dev_oe), .host_data_bus(bus.host_data_bus));

  wire strobe_n = ~(bus.data_strobe_one ^ bus.data_strobe_two) | bus.host_chip_select;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Writes land at the edge; the wire's first write half is kept for checking.
  always @(posedge clock) begin
    if (mem_wr_valid === 1'b1 && mem_wr_ready) mem[mem_wr_addr] = mem_wr_data;
    strobe_q <= strobe_n;
    if (!strobe_n && strobe_q) wr_low_q <= !bus.read_write_select && !bus.halfword_identifier;
    if (strobe_n && !strobe_q && wr_low_q) low_half_q <= bus.host_data_bus;
  end

  // Memory side; idle read data toggles so stale values never look valid.
  always @(negedge clock) begin
    mem_wr_ready <= (stall > 0) ? 1'b0 : 1'($random(seed));
    if (stall > 0) stall--;
    mem_rd_valid <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    if (mem_rd_req === 1'b1 && !mem_rd_valid) begin
      if (rd_wait == 0) begin
        mem_rd_valid <= 1'b1;
        mem_rd_data <= mem.exists(mem_rd_addr) ? mem[mem_rd_addr] : 32'h0000_0000;
        rd_wait <= $random(seed) & 3;
      end else rd_wait <= rd_wait - 1;
    end
  end

  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : 32'h0000_0000;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One command to the host end; the address strobe mode is drawn per access.
  task automatic acc(input logic [1:0] t, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(negedge clock);
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    use_addr_strobe = 1'($random(seed));
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_write = w;
    cmd_wdata = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) mismatches++;
    r = resp_rdata;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    finish_test;
  end

  initial begin
    logic [31:0] r, a, d;
    {use_addr_strobe, cmd_valid, cmd_write, cmd_type, cmd_wdata} = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    // Control round trip with the data path idle.
    acc(ACC_CTRL, 1'b1, 32'hA5C3_5A3C, r);
    check(ctrl_word, 32'hA5C3_5A3C);
    acc(ACC_CTRL, 1'b0, 32'h0000_0000, r);
    check(r, 32'hA5C3_5A3C);
    // Fixed writes then reads; a read must wait for the queued write.
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 32'h0000_00FC : ({$random(seed)} & 32'h0000_00FC);
      d = $random(seed);
      acc(ACC_ADDR, 1'b1, a, r);
      acc(ACC_DATA_FIX, 1'b1, d, r);
      exp_mem[a] = d;
      check({16'h0000, low_half_q}, {16'h0000, d[15:0]});
      acc(ACC_DATA_FIX, 1'b0, 32'h0000_0000, r);
      check(r, exp_rd(a));
      acc(ACC_ADDR, 1'b0, 32'h0000_0000, r);
      check(r, a);
    end
    // Burst into a stalled memory fills the FIFO, then it drains.
    stall = 900;
    a = 32'h0000_0100;
    acc(ACC_ADDR, 1'b1, a, r);
    for (int i = 0; i < 34; i++) begin
      d = $random(seed);
      exp_mem[a + i * ADDR_STEP] = d;
      acc(ACC_DATA_INC, 1'b1, d, r);
    end
    acc(ACC_ADDR, 1'b0, 32'h0000_0000, r);
    check(r, a + 34 * ADDR_STEP);
    acc(ACC_ADDR, 1'b1, a, r);
    for (int i = 0; i < 34; i++) begin
      acc(ACC_DATA_INC, 1'b0, 32'h0000_0000, r);
      check(r, exp_rd(a + i * ADDR_STEP));
    end
    finish_test;
  end
endmodule
